//--- core/wdt_cfg.svh
/*
  Constants of the watchdog timer: register index and address, control bit
  positions, reset values, counter and prescaler widths, timeout figures.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_ADDR_W        20
`define WDT_CTRL_INDEX    20'h0FF53
`define WDT_CTRL_ADDR     (`WDT_CTRL_INDEX * 20'h00004)

`define WDT_BIT_UNLOCK    7
`define WDT_BIT_IRQ_EN    6
`define WDT_BIT_CLK_SEL   5
`define WDT_BIT_CLEAR     0

`define WDT_RST_UNLOCK    1'b0
`define WDT_RST_IRQ_EN    1'b1
`define WDT_RST_CLK_SEL   1'b0
`define WDT_RST_COUNT     12'h000

`define WDT_CNT_W         12
`define WDT_CNT_MAX       12'hFFF
`define WDT_PRE_W         4
`define WDT_PRE_MAX       4'hF

`define WDT_SLOW_OSC_HZ   32768
`define WDT_DIVIDE        16
`define WDT_TIMEOUT_S     2
`define WDT_SLOW_TIMEOUT_S ((4096 * `WDT_DIVIDE) / `WDT_SLOW_OSC_HZ)

`define WDT_NMI_LEVEL     3'h4
`define WDT_NMI_VECTOR    24'h000004

`endif

//--- core/wdt_pkg.sv
/*
  Types of the watchdog timer.
  Assumes wdt_cfg.svh on the include path.
*/
`include "wdt_cfg.svh"

package wdt_pkg;

  typedef logic [`WDT_CNT_W-1:0]  wdt_count_t;
  typedef logic [`WDT_ADDR_W-1:0] wdt_addr_t;

  typedef enum logic [1:0] {
    WDT_BUS_IDLE = 2'b01,
    WDT_BUS_ACK  = 2'b10
  } wdt_bus_state_t;

endpackage : wdt_pkg

//--- core/wdt_osc_tick.sv
/*
  One oscillator input turned into a divide-by-16 tick on ref_clk_i.
  Assumes osc_i is an asynchronous pin far slower than ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

`include "wdt_cfg.svh"

module wdt_osc_tick (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic osc_i,
  output var  logic tick_o
);
  import wdt_pkg::*;

  logic                  sync1_r;
  logic                  sync2_r;
  logic                  prev_r;
  logic [`WDT_PRE_W-1:0] pre_r;
  logic                  rise;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= osc_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;

  // one tick every sixteenth rising edge of the oscillator
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pre_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= rise && (pre_r == `WDT_PRE_MAX);
      if (rise) begin
        pre_r <= pre_r + 4'h1;
      end
    end
  end

endmodule : wdt_osc_tick

`default_nettype wire

//--- core/wdt_top.sv
/*
  Watchdog timer with APB control register and NMI request to the CPU.
  Assumes oscillator pins asynchronous to ref_clk_i; halt_i and sleep_i come
  from the power controller on ref_clk_i.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "wdt_cfg.svh"

// Contract
// - counter is 12 bits, advanced by the selected divided oscillator
// - overflow without a software clear raises the CPU NMI
// - bit 5 selects fast or slow oscillator over 16, resets slow
// - slow oscillator at 32.768 kHz gives about 2 s to overflow
// - writing one to bit 0 clears counter; zero ignored; reads zero
// - enable and select writes ignored unless unlocked
// - unlock bit 7 allows one write; that write relocks
// - writing zero to a set unlock bit relocks
// - unlock bit reads back its value and resets to zero
// - bit 6 zero suppresses the interrupt; resets to one
// - counting goes on while the interrupt is disabled
// - after reset counting starts at once, slow clock, interrupt armed
// - counting continues in HALT; overflow there raises NMI, ends HALT
// - SLEEP freezes the counter; counting resumes from held value
// - request goes to the level 4 NMI input, vector 000004H
module wdt_top (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire wdt_pkg::wdt_addr_t paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output var  logic [31:0]      prdata_o,
  output var  logic             pready_o,
  output var  logic             pslverr_o,
  input  wire logic             low_speed_oscillator_i,
  input  wire logic             high_speed_oscillator_i,
  input  wire logic             halt_i,
  input  wire logic             sleep_i,
  output var  logic             nmi_o,
  output var  logic [2:0]       nmi_level_o,
  output var  logic             halt_release_o
);
  import wdt_pkg::*;

  wdt_bus_state_t bus_state_r;
  wdt_bus_state_t bus_state_nxt;
  wdt_count_t     count_r;
  logic           protect_unlock_r;
  logic           timeout_irq_enable_r;
  logic           count_clock_select_r;
  logic [1:0]     osc_tick;
  logic           cnt_tick;
  logic           bus_done;
  logic           addr_hit;
  logic           ctrl_wr;
  logic           counter_clear_strobe;
  logic           overflow;

  function automatic logic hit_ctrl(input wdt_addr_t a);
    hit_ctrl = (a == `WDT_CTRL_ADDR);
  endfunction : hit_ctrl

  // ---------------- oscillator ticks, index 0 slow, 1 fast
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_osc
      wdt_osc_tick u_tick (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .osc_i     (g == 0 ? low_speed_oscillator_i
                           : high_speed_oscillator_i),
        .tick_o    (osc_tick[g])
      );
    end
  endgenerate

  // ---------------- APB slave, one wait state
  always_comb begin
    bus_state_nxt = WDT_BUS_IDLE;
    case (bus_state_r)
      WDT_BUS_IDLE: begin
        if (psel_i && penable_i) begin
          bus_state_nxt = WDT_BUS_ACK;
        end
      end
      WDT_BUS_ACK: begin
        bus_state_nxt = WDT_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = WDT_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bus_state_r <= WDT_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  assign bus_done = psel_i && penable_i && pready_o;
  assign addr_hit = hit_ctrl(paddr_i);
  assign ctrl_wr  = bus_done && pwrite_i && addr_hit;
  assign counter_clear_strobe = ctrl_wr && pwdata_i[`WDT_BIT_CLEAR];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= (bus_state_nxt == WDT_BUS_ACK);
      pslverr_o <= (bus_state_nxt == WDT_BUS_ACK) && !addr_hit;
      prdata_o  <= 32'h0000_0000;
      if ((bus_state_nxt == WDT_BUS_ACK) && !pwrite_i && addr_hit) begin
        prdata_o[`WDT_BIT_UNLOCK]  <= protect_unlock_r;
        prdata_o[`WDT_BIT_IRQ_EN]  <= timeout_irq_enable_r;
        prdata_o[`WDT_BIT_CLK_SEL] <= count_clock_select_r;
      end
    end
  end

  // ---------------- write protection
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      protect_unlock_r     <= `WDT_RST_UNLOCK;
      timeout_irq_enable_r <= `WDT_RST_IRQ_EN;
      count_clock_select_r <= `WDT_RST_CLK_SEL;
    end else if (ctrl_wr) begin
      if (protect_unlock_r) begin
        // the one permitted write; any write relocks
        timeout_irq_enable_r <= pwdata_i[`WDT_BIT_IRQ_EN];
        count_clock_select_r <= pwdata_i[`WDT_BIT_CLK_SEL];
        protect_unlock_r     <= 1'b0;
      end else begin
        protect_unlock_r <= pwdata_i[`WDT_BIT_UNLOCK];
      end
    end
  end

  // ---------------- counter
  // prescalers run on in SLEEP; their ticks are not taken then
  assign cnt_tick = (count_clock_select_r ? osc_tick[1] : osc_tick[0])
                    && !sleep_i;
  assign overflow = cnt_tick && (count_r == `WDT_CNT_MAX)
                    && !counter_clear_strobe;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_r <= `WDT_RST_COUNT;
    end else if (counter_clear_strobe) begin
      count_r <= `WDT_RST_COUNT;
    end else if (cnt_tick) begin
      // wraps from all ones to zero, enable or not
      count_r <= count_r + 12'h001;
    end
  end

  // ---------------- NMI request and HALT release
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      nmi_o          <= 1'b0;
      nmi_level_o    <= `WDT_NMI_LEVEL;
      halt_release_o <= 1'b0;
    end else begin
      nmi_o          <= overflow && timeout_irq_enable_r;
      nmi_level_o    <= `WDT_NMI_LEVEL;
      halt_release_o <= overflow && timeout_irq_enable_r
                        && halt_i;
    end
  end

  // ---------------- checks
  sequence s_access;
    psel_i && !penable_i ##1 psel_i && penable_i && !pready_o;
  endsequence

  sequence s_clear_write;
    ctrl_wr && pwdata_i[`WDT_BIT_CLEAR];
  endsequence

  property p_ready;
    @(posedge ref_clk_i) disable iff (reset_i)
      s_access |=> pready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready one cycle into access");

  property p_clear;
    @(posedge ref_clk_i) disable iff (reset_i)
      s_clear_write |=> (count_r == 12'h000) && !nmi_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared by clear write");

  property p_count;
    @(posedge ref_clk_i) disable iff (reset_i)
      cnt_tick && !counter_clear_strobe
      |=> count_r == $past(count_r) + 12'h001;
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not advance on tick");

  property p_nmi;
    @(posedge ref_clk_i) disable iff (reset_i)
      cnt_tick && (count_r == 12'hFFF) && !counter_clear_strobe
      && timeout_irq_enable_r |=> nmi_o && (count_r == 12'h000);
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("overflow gave no NMI or no wrap");

  property p_masked;
    @(posedge ref_clk_i) disable iff (reset_i)
      !timeout_irq_enable_r |=> !nmi_o;
  endproperty
  a_masked: assert property (p_masked)
    else $error("NMI while disabled");

  property p_locked;
    @(posedge ref_clk_i) disable iff (reset_i)
      ctrl_wr && !protect_unlock_r
      |=> $stable(timeout_irq_enable_r) && $stable(count_clock_select_r);
  endproperty
  a_locked: assert property (p_locked)
    else $error("protected bit changed while locked");

  property p_oneshot;
    @(posedge ref_clk_i) disable iff (reset_i)
      ctrl_wr && protect_unlock_r |=> !protect_unlock_r
      && (timeout_irq_enable_r == $past(pwdata_i[`WDT_BIT_IRQ_EN]));
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("unlock not consumed by write");

  property p_sleep;
    @(posedge ref_clk_i) disable iff (reset_i)
      sleep_i && !counter_clear_strobe |=> $stable(count_r);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("counter moved in sleep");

  property p_halt;
    @(posedge ref_clk_i) disable iff (reset_i)
      overflow && timeout_irq_enable_r && halt_i
      |=> halt_release_o && nmi_o ##1 !halt_release_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt not released by NMI");

  property p_read_clear_bit;
    @(posedge ref_clk_i) disable iff (reset_i)
      pready_o |-> !prdata_o[`WDT_BIT_CLEAR] && (prdata_o[31:8] == 24'h0);
  endproperty
  a_read_clear_bit: assert property (p_read_clear_bit)
    else $error("write-only bit read as one");

  property p_reset_state;
    @(posedge ref_clk_i)
      reset_i |=> !protect_unlock_r && timeout_irq_enable_r
      && !count_clock_select_r && (count_r == 12'h000);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("control or counter not at reset value");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (reset_i)
      cnt_tick && (count_r == 12'hFFF) && !counter_clear_strobe
      |=> count_r == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to zero");

  property p_slow_only;
    @(posedge ref_clk_i) disable iff (reset_i)
      !count_clock_select_r && !osc_tick[0] && !counter_clear_strobe
      |=> $stable(count_r);
  endproperty
  a_slow_only: assert property (p_slow_only)
    else $error("counter moved without a slow tick");

  property p_fast_only;
    @(posedge ref_clk_i) disable iff (reset_i)
      count_clock_select_r && !osc_tick[1] && !counter_clear_strobe
      |=> $stable(count_r);
  endproperty
  a_fast_only: assert property (p_fast_only)
    else $error("counter moved without a fast tick");

  property p_unlock_set;
    @(posedge ref_clk_i) disable iff (reset_i)
      ctrl_wr && !protect_unlock_r
      |=> protect_unlock_r == $past(pwdata_i[`WDT_BIT_UNLOCK]);
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock bit did not take written value");

  property p_level;
    @(posedge ref_clk_i) disable iff (reset_i)
      nmi_o |-> nmi_level_o == `WDT_NMI_LEVEL;
  endproperty
  a_level: assert property (p_level)
    else $error("NMI raised at wrong level");

  property p_halt_cause;
    @(posedge ref_clk_i) disable iff (reset_i)
      halt_release_o |-> nmi_o && $past(halt_i);
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("halt release without NMI in halt");

endmodule : wdt_top

`default_nettype wire

//--- verif/wdt_cpu_model.sv
/*
  Model of the CPU core that receives the watchdog NMI: counts requests,
  keeps the level seen, enters HALT on request and leaves it on release.
  Assumes the same clock and reset as wdt_top.
*/
`timescale 1ns/1ps
`default_nettype none

module wdt_cpu_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       nmi_i,
  input  wire logic [2:0] nmi_level_i,
  input  wire logic       halt_release_i,
  input  wire logic       halt_req_i,
  output var  logic       halt_o,
  output var  int         nmi_count_o,
  output var  logic [2:0] level_o
);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      halt_o <= 1'b0;
    end else if (halt_release_i) begin
      halt_o <= 1'b0;
    end else if (halt_req_i) begin
      halt_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      nmi_count_o <= 0;
      level_o     <= 3'h0;
    end else if (nmi_i) begin
      nmi_count_o <= nmi_count_o + 1;
      level_o     <= nmi_level_i;
    end
  end
endmodule : wdt_cpu_model

`default_nettype wire

//--- verif/watchdog_nmi_timer_tb.sv
/*
  Self-checking bench of wdt_top: one timeout in HALT with a SLEEP window,
  then control
  register checks with corner and random writes.
  Assumes wdt_cfg.svh and wdt_pkg on the compile path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module watchdog_nmi_timer_tb;
  import wdt_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  wdt_addr_t   paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic        pready_o, pslverr_o, nmi_o, halt_release_o, halt_i, err;
  logic        slow_osc = 1'b0, halt_req = 1'b0;
  logic        fast_osc = 1'b0, sleep = 1'b0;
  logic [2:0]  nmi_level_o, level, st;
  int          nmi_count, fail_count = 0, samples_checked = 0;
  logic [31:0] lfsr = 32'hC9434779;

  always #5 ref_clk_i = ~ref_clk_i;

  // fast oscillator runs free; it only counts while selected
  always @(posedge ref_clk_i) fast_osc <= ~fast_osc;

  wdt_top u_wdt_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .low_speed_oscillator_i(slow_osc), .high_speed_oscillator_i(fast_osc),
    .halt_i(halt_i), .sleep_i(sleep), .nmi_o(nmi_o),
    .nmi_level_o(nmi_level_o), .halt_release_o(halt_release_o));

  wdt_cpu_model u_wdt_cpu_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .nmi_i(nmi_o), .nmi_level_i(nmi_level_o),
    .halt_release_i(halt_release_o), .halt_req_i(halt_req),
    .halt_o(halt_i), .nmi_count_o(nmi_count), .level_o(level));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next

  // state is {unlock, irq enable, clock select}
  function automatic logic [2:0] reg_next(input logic [2:0] s,
                                          input logic [7:0] d);
    return s[2] ? {1'b0, d[6], d[5]} : {d[7], s[1:0]};
  endfunction : reg_next

  task print_verdict;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task apb(input logic wr, input wdt_addr_t a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr;
    paddr_i <= a; pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb

  task wr_rd(input logic [7:0] d);
    apb(1'b1, `WDT_CTRL_ADDR, {24'h000000, d});
    st = reg_next(st, d);
    apb(1'b0, `WDT_CTRL_ADDR, 32'h00000000);
    `CHK("control", {24'h000000, st, 5'h00}, rd)
    `CHK("pslverr", 1'b0, err)
  endtask : wr_rd

  // pin changes on clock edges, so one clock high and one low is enough
  // for the synchroniser to see every rising edge
  task osc_period;
    slow_osc <= 1'b1;
    @(posedge ref_clk_i);
    slow_osc <= 1'b0;
    @(posedge ref_clk_i);
  endtask : osc_period

  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    halt_req <= 1'b1;
    @(posedge ref_clk_i);
    halt_req <= 1'b0;
    repeat (30000) osc_period();
    repeat (4) @(posedge ref_clk_i);
    sleep <= 1'b1;
    // rises in sleep move only the prescaler: two ticks are dropped
    repeat (32) osc_period();
    repeat (4) @(posedge ref_clk_i);
    sleep <= 1'b0;
    repeat (35535) osc_period();
    `CHK("nmi early", 0, nmi_count)
    `CHK("nmi idle", 1'b0, nmi_o)
    osc_period();
    for (int n = 0; n < 40 && nmi_count == 0; n++) @(posedge ref_clk_i);
    repeat (4) @(posedge ref_clk_i);
    `CHK("nmi count", 1, nmi_count)
    `CHK("nmi level", 3'h4, level)
    `CHK("halt left", 1'b0, halt_i)
    reset_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    st = 3'b010;
    apb(1'b0, `WDT_CTRL_ADDR, 32'h00000000);
    `CHK("reset value", 32'h00000040, rd)
    wr_rd(8'h20);
    wr_rd(8'h80);
    wr_rd(8'h20);
    // fast clock selected now: clear, sleep while ticks arrive, clear
    wr_rd(8'h01);
    sleep <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    sleep <= 1'b0;
    wr_rd(8'h01);
    wr_rd(8'h80);
    wr_rd(8'h00);
    wr_rd(8'h80);
    wr_rd(8'h41);
    wr_rd(8'h01);
    repeat (16) begin
      lfsr = lfsr_next(lfsr);
      wr_rd(lfsr[7:0]);
    end
    apb(1'b1, `WDT_CTRL_ADDR + 20'h00004, 32'h000000FF);
    `CHK("unmapped write", 1'b1, err)
    apb(1'b0, `WDT_CTRL_ADDR, 32'h00000000);
    `CHK("after unmapped", {24'h000000, st, 5'h00}, rd)
    apb(1'b0, `WDT_CTRL_ADDR + 20'h00004, 32'h00000000);
    `CHK("unmapped read", 32'h00000000, rd)
    wr_rd(8'h00);
    `CHK("no nmi", 0, nmi_count)
    print_verdict();
  end
endmodule : watchdog_nmi_timer_tb

`default_nettype wire
